// ===== hdl/sfs_core.sv
// serial flash status, write-enable and extended address instruction handling
`include "sfs_map.svh"
`default_nettype none

module sfs_core
	import sfs_pkg::*;
#(
	parameter int NV_WRITE_NS = `SFS_NV_WRITE_NS
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        spi_cs_n_in,
	input  wire logic        spi_clk_in,
	input  wire logic        serial_in_pin_in,
	input  wire logic        dev_reset_in,
	input  wire logic        mem_op_done_in,
	input  wire logic        addr_hi_valid_in,
	input  wire logic [7:0]  addr_hi_in,
	output logic             serial_out_out,
	output logic             serial_out_oe_out,
	output sfs_stat_t        status_out,
	output logic [7:0]       ext_addr_out,
	output logic             ext_addr_active_out
);

	// ------------------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------------------
	localparam longint NV_CYC_L  = (longint'(NV_WRITE_NS) * `SFS_CLK_MHZ + 999) / 1000;
	localparam longint VOL_CYC_L = (longint'(`SFS_VOL_REFRESH_NS) * `SFS_CLK_MHZ) / 1000;
	localparam logic [`SFS_TIMER_W-1:0] NV_CYC  =
		(NV_CYC_L < 1) ? `SFS_TIMER_W'(1) : `SFS_TIMER_W'(NV_CYC_L);
	localparam logic [`SFS_TIMER_W-1:0] VOL_CYC =
		(VOL_CYC_L < 1) ? `SFS_TIMER_W'(1) : `SFS_TIMER_W'(VOL_CYC_L);

	localparam sfs_stat_t NV_RESET = '{
		sr3: `SFS_SR3_RESET,
		sr2: `SFS_SR2_RESET,
		sr1: `SFS_SR1_RESET
	};

	// ------------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------------
	logic [2:0] pins_s;
	logic       cs_n_s;
	logic       sclk_s;
	logic       di_s;

	sfs_sync #(
		.WIDTH     (3),
		.RESET_VAL (3'h4)
	) u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.async_in ({spi_cs_n_in, spi_clk_in, serial_in_pin_in}),
		.sync_out (pins_s)
	);

	assign cs_n_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign di_s   = pins_s[0];

	// ------------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------------
	function automatic logic [7:0] merge(input logic [7:0] old_v,
	                                     input logic [7:0] new_v,
	                                     input logic [7:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	function automatic logic is_read(input logic [7:0] op);
		is_read = (op == `SFS_OP_RD_SR1) || (op == `SFS_OP_RD_SR2) ||
		          (op == `SFS_OP_RD_SR3) || (op == `SFS_OP_RD_EXT);
	endfunction

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	sfs_state_t st;
	sfs_state_t next_st;

	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_rise;
	logic       selected;
	logic [7:0] rd_val;
	logic       wr_stat;
	logic       wr_len_ok;
	logic       two_byte;
	logic       busy;
	sfs_stat_t  base;
	sfs_stat_t  cand;

	assign sclk_rise = sclk_s & ~st.clk_d;
	assign sclk_fall = ~sclk_s & st.clk_d;
	assign cs_rise   = cs_n_s & ~st.cs_d;
	assign selected  = ~cs_n_s;
	assign busy      = st.vol.sr1[`SFS_SR1_BUSY];

	always_comb begin
		next_st = st;
		rd_val  = 8'h00;
		base    = st.vol;
		cand    = st.vol;
		next_st.cs_d  = cs_n_s;
		next_st.clk_d = sclk_s;

		// --------------------------------------------------------------------
		// value chosen for a read, fetched fresh at every byte
		// --------------------------------------------------------------------
		case (st.opcode)
			`SFS_OP_RD_SR1: rd_val = st.vol.sr1;
			`SFS_OP_RD_SR2: rd_val = st.vol.sr2;
			`SFS_OP_RD_SR3: rd_val = st.vol.sr3;
			`SFS_OP_RD_EXT: rd_val = st.ext_addr;
			default:        rd_val = 8'h00;
		endcase

		// --------------------------------------------------------------------
		// serial shifter
		// --------------------------------------------------------------------
		if (!selected) begin
			next_st.bit_cnt = 6'h00;
			next_st.out_idx = 3'h0;
			next_st.so_oe   = 1'b0;
		end else begin
			if (sclk_rise) begin
				next_st.shift = {st.shift[6:0], di_s};
				if (st.bit_cnt != `SFS_CNT_MAX) begin
					next_st.bit_cnt = st.bit_cnt + 6'h01;
				end
				if (st.bit_cnt == `SFS_LEN_OPCODE - 6'h01) begin
					next_st.opcode = {st.shift[6:0], di_s};
					next_st.byte1  = 8'h00;
					next_st.byte2  = 8'h00;
				end
				if (st.bit_cnt == `SFS_LEN_ONE_BYTE - 6'h01) begin
					next_st.byte1 = {st.shift[6:0], di_s};
				end
				if (st.bit_cnt == `SFS_LEN_TWO_BYTE - 6'h01) begin
					next_st.byte2 = {st.shift[6:0], di_s};
				end
			end
			// output phase repeats the selected register until deselect
			if (sclk_fall && st.bit_cnt >= `SFS_LEN_OPCODE && is_read(st.opcode)) begin
				next_st.so_oe   = 1'b1;
				next_st.out_idx = st.out_idx + 3'h1;
				if (st.out_idx == 3'h0) begin
					next_st.so      = rd_val[7];
					next_st.out_buf = {rd_val[6:0], 1'b0};
				end else begin
					next_st.so      = st.out_buf[7];
					next_st.out_buf = {st.out_buf[6:0], 1'b0};
				end
			end
		end

		// --------------------------------------------------------------------
		// self-timed cycles
		// --------------------------------------------------------------------
		if (st.tmode != SFS_TM_IDLE) begin
			if (st.timer > `SFS_TIMER_W'(1)) begin
				next_st.timer = st.timer - `SFS_TIMER_W'(1);
			end else begin
				next_st.tmode = SFS_TM_IDLE;
				next_st.timer = '0;
				if (st.tmode == SFS_TM_NV) begin
					next_st.nv      = st.pend;
					next_st.vol.sr1 = merge(st.vol.sr1, st.pend.sr1, `SFS_SR1_WR_MASK);
					next_st.vol.sr2 = merge(st.vol.sr2, st.pend.sr2, `SFS_SR2_WR_MASK);
					next_st.vol.sr3 = merge(st.vol.sr3, st.pend.sr3, `SFS_SR3_WR_MASK);
					next_st.vol.sr1[`SFS_SR1_BUSY] = 1'b0;
					next_st.vol.sr1[`SFS_SR1_WEL]  = 1'b0;
				end else begin
					next_st.vol.sr1 = merge(st.vol.sr1, st.pend.sr1, `SFS_SR1_WR_MASK);
					next_st.vol.sr2 = merge(st.vol.sr2, st.pend.sr2, `SFS_SR2_WR_MASK);
					next_st.vol.sr3 = merge(st.vol.sr3, st.pend.sr3, `SFS_SR3_WR_MASK);
				end
			end
		end

		// outside operations that finish clear the latch before any set below
		if (mem_op_done_in) begin
			next_st.vol.sr1[`SFS_SR1_WEL] = 1'b0;
		end

		// four-byte mode: a top address byte replaces the register unless a device reset or an extended address write lands in the same cycle
		if (addr_hi_valid_in && st.vol.sr3[`SFS_SR3_ADS]) begin
			next_st.ext_addr = addr_hi_in;
		end

		// --------------------------------------------------------------------
		// decode when select rises
		// --------------------------------------------------------------------
		two_byte  = (st.opcode == `SFS_OP_WR_SR1) && (st.bit_cnt == `SFS_LEN_TWO_BYTE);
		wr_stat   = (st.opcode == `SFS_OP_WR_SR1) || (st.opcode == `SFS_OP_WR_SR2) ||
		            (st.opcode == `SFS_OP_WR_SR3);
		wr_len_ok = (st.bit_cnt == `SFS_LEN_ONE_BYTE) || two_byte;
		base      = st.vol_arm ? st.vol : st.nv;
		cand      = base;
		case (st.opcode)
			`SFS_OP_WR_SR1: begin
				cand.sr1 = merge(base.sr1, st.byte1, `SFS_SR1_WR_MASK);
				if (two_byte) begin
					cand.sr2 = merge(base.sr2, st.byte2, `SFS_SR2_WR_MASK);
				end
			end
			`SFS_OP_WR_SR2: cand.sr2 = merge(base.sr2, st.byte1, `SFS_SR2_WR_MASK);
			`SFS_OP_WR_SR3: cand.sr3 = merge(base.sr3, st.byte1, `SFS_SR3_WR_MASK);
			default:        cand     = base;
		endcase
		if (st.vol_arm) begin
			cand.sr2 = cand.sr2 | (base.sr2 & `SFS_SR2_VOL_KEEP);
		end else begin
			cand.sr2 = cand.sr2 | (base.sr2 & `SFS_SR2_OTP_MASK);
		end

		if (cs_rise && !busy) begin
			if (st.bit_cnt == `SFS_LEN_OPCODE) begin
				case (st.opcode)
					`SFS_OP_WREN:     next_st.vol.sr1[`SFS_SR1_WEL] = 1'b1;
					`SFS_OP_WREN_VOL: next_st.vol_arm = 1'b1;
					`SFS_OP_WRDIS:    next_st.vol.sr1[`SFS_SR1_WEL] = 1'b0;
					`SFS_OP_ENTER_4B: next_st.vol.sr3[`SFS_SR3_ADS] = 1'b1;
					`SFS_OP_EXIT_4B:  next_st.vol.sr3[`SFS_SR3_ADS] = 1'b0;
					default:          next_st.vol_arm = st.vol_arm;
				endcase
			end else if (wr_stat && wr_len_ok) begin
				if (st.vol_arm) begin
					next_st.pend    = cand;
					next_st.tmode   = SFS_TM_VOL;
					next_st.timer   = VOL_CYC;
					next_st.vol_arm = 1'b0;
				end else if (st.vol.sr1[`SFS_SR1_WEL]) begin
					next_st.pend  = cand;
					next_st.tmode = SFS_TM_NV;
					next_st.timer = NV_CYC;
					next_st.vol.sr1[`SFS_SR1_BUSY] = 1'b1;
				end
			end else if (st.opcode == `SFS_OP_WR_EXT && st.bit_cnt == `SFS_LEN_ONE_BYTE &&
			             st.vol.sr1[`SFS_SR1_WEL]) begin
				next_st.ext_addr = st.byte1;
			end
		end

		// --------------------------------------------------------------------
		// software or hardware reset: volatile state falls back to nv
		// --------------------------------------------------------------------
		if (dev_reset_in) begin
			next_st.vol      = st.nv;
			next_st.vol.sr1[`SFS_SR1_BUSY] = 1'b0;
			next_st.vol.sr1[`SFS_SR1_WEL]  = 1'b0;
			next_st.vol.sr3[`SFS_SR3_ADS]  = st.nv.sr3[`SFS_SR3_ADP];
			next_st.ext_addr = `SFS_EXT_RESET;
			next_st.vol_arm  = 1'b0;
			next_st.tmode    = SFS_TM_IDLE;
			next_st.timer    = '0;
		end

		next_st.ext_active = ~next_st.vol.sr3[`SFS_SR3_ADS];
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			st            <= '0;
			st.cs_d       <= 1'b1;
			st.nv         <= NV_RESET;
			st.pend       <= NV_RESET;
			st.vol        <= NV_RESET;
			st.vol.sr3[`SFS_SR3_ADS] <= NV_RESET.sr3[`SFS_SR3_ADP];
			st.ext_addr   <= `SFS_EXT_RESET;
			st.ext_active <= ~NV_RESET.sr3[`SFS_SR3_ADP];
			st.tmode      <= SFS_TM_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign serial_out_out      = st.so;
	assign serial_out_oe_out   = st.so_oe;
	assign status_out          = st.vol;
	assign ext_addr_out        = st.ext_addr;
	assign ext_addr_active_out = st.ext_active;

endmodule

`default_nettype wire

// ===== include/sfs_map.svh
// opcodes, field positions, reset values and timing of the status command block
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define SFS_OP_WREN         8'h06
`define SFS_OP_WREN_VOL     8'h50
`define SFS_OP_WRDIS        8'h04
`define SFS_OP_RD_SR1       8'h05
`define SFS_OP_RD_SR2       8'h35
`define SFS_OP_RD_SR3       8'h15
`define SFS_OP_WR_SR1       8'h01
`define SFS_OP_WR_SR2       8'h31
`define SFS_OP_WR_SR3       8'h11
`define SFS_OP_RD_EXT       8'hC8
`define SFS_OP_WR_EXT       8'hC5
`define SFS_OP_ENTER_4B     8'hB7
`define SFS_OP_EXIT_4B      8'hE9

// ----------------------------------------------------------------------------
// frame lengths in serial clocks
// ----------------------------------------------------------------------------
`define SFS_LEN_OPCODE      6'h08
`define SFS_LEN_ONE_BYTE    6'h10
`define SFS_LEN_TWO_BYTE    6'h18
`define SFS_CNT_MAX         6'h3F

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SFS_SR1_BUSY        0
`define SFS_SR1_WEL         1
`define SFS_SR3_ADS         0
`define SFS_SR3_ADP         1

// writable bits: top_bottom_select, block_protect_bits / protect_complement,
// security_lock_bits, quad_io_allow, status_reg_lock / drive strength, scheme, addr default
`define SFS_SR1_WR_MASK     8'h7C
`define SFS_SR2_WR_MASK     8'h7B
`define SFS_SR3_WR_MASK     8'h66
// bits that may not fall from 1 to 0
`define SFS_SR2_OTP_MASK    8'h38
`define SFS_SR2_VOL_KEEP    8'h39

// ----------------------------------------------------------------------------
// reset values of the non-volatile copies and of the extended address register
// ----------------------------------------------------------------------------
`define SFS_SR1_RESET       8'h00
`define SFS_SR2_RESET       8'h02
`define SFS_SR3_RESET       8'h60
`define SFS_EXT_RESET       8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SFS_CLK_MHZ         250
`define SFS_NV_WRITE_NS     10000
`define SFS_VOL_REFRESH_NS  50
`define SFS_TIMER_W         32

`endif

// ===== include/sfs_pkg.sv
// types shared by the status command block
`include "sfs_map.svh"
`default_nettype none

package sfs_pkg;

	typedef struct packed {
		logic [7:0] sr3;
		logic [7:0] sr2;
		logic [7:0] sr1;
	} sfs_stat_t;

	typedef enum logic [1:0] {
		SFS_TM_IDLE,
		SFS_TM_NV,
		SFS_TM_VOL
	} sfs_tmode_t;

	typedef struct packed {
		logic                      cs_d;
		logic                      clk_d;
		logic [5:0]                bit_cnt;
		logic [7:0]                shift;
		logic [7:0]                opcode;
		logic [7:0]                byte1;
		logic [7:0]                byte2;
		logic [7:0]                out_buf;
		logic [2:0]                out_idx;
		logic                      so;
		logic                      so_oe;
		sfs_stat_t                 vol;
		sfs_stat_t                 nv;
		sfs_stat_t                 pend;
		logic [7:0]                ext_addr;
		logic                      ext_active;
		logic                      vol_arm;
		sfs_tmode_t                tmode;
		logic [`SFS_TIMER_W-1:0]   timer;
	} sfs_state_t;

endpackage

`default_nettype wire

// ===== hdl/sfs_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`default_nettype none

module sfs_sync #(
	parameter int          WIDTH     = 3,
	parameter logic [2:0]  RESET_VAL = 3'h0
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			meta     <= RESET_VAL[WIDTH-1:0];
			sync_out <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// ===== testbench/sfs_core_asserts.sv
// assertion checker for the status command block
`default_nettype none

module sfs_core_asserts
	import sfs_pkg::*;
#(
	parameter int NV_WRITE_NS = 3600
) (
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic       spi_cs_n_in,
	input wire logic       spi_clk_in,
	input wire logic       serial_in_pin_in,
	input wire logic       dev_reset_in,
	input wire logic       mem_op_done_in,
	input wire logic       addr_hi_valid_in,
	input wire logic [7:0] addr_hi_in,
	input wire logic       serial_out_out,
	input wire logic       serial_out_oe_out,
	input wire sfs_stat_t  status_out,
	input wire logic [7:0] ext_addr_out,
	input wire logic       ext_addr_active_out
);
	// ----------------------------------------
	// select-high counter and properties
	// ----------------------------------------
	localparam int BUSY_MAX = NV_WRITE_NS / 4 + 4;
	logic [3:0] hi_cnt;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) hi_cnt <= 4'h0;
		else if (!spi_cs_n_in) hi_cnt <= 4'h0;
		else if (hi_cnt != 4'hF) hi_cnt <= hi_cnt + 4'h1;
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	chk_ext_clear: assert property (dev_reset_in |=> ext_addr_out == 8'h00)
		else $error("ext addr kept after device reset");
	chk_reset_wel: assert property (dev_reset_in |=> status_out.sr1[1:0] == 2'h0)
		else $error("latch or busy kept after device reset");
	chk_hi_load: assert property (addr_hi_valid_in && !dev_reset_in && !ext_addr_active_out
		|=> ext_addr_out == $past(addr_hi_in)) else $error("top address byte not taken");
	chk_hi_ignore: assert property (addr_hi_valid_in && ext_addr_active_out && hi_cnt > 4'h7
		&& !dev_reset_in |=> $stable(ext_addr_out)) else $error("ext addr changed in 3-byte mode");
	chk_mode_flag: assert property (ext_addr_active_out == !status_out.sr3[0])
		else $error("ext active flag disagrees with mode");
	chk_done_wel: assert property (mem_op_done_in && hi_cnt > 4'h7 |=> !status_out.sr1[1])
		else $error("latch kept after memory op done");
	chk_oe_idle: assert property (hi_cnt > 4'h5 |-> !serial_out_oe_out)
		else $error("serial out driven with select high");
	chk_so_fall: assert property ($changed(serial_out_out) |-> !spi_clk_in)
		else $error("serial out moved while serial clock high");
	chk_busy_min: assert property ($rose(status_out.sr1[0]) |-> status_out.sr1[0] [*8])
		else $error("busy too short");
	chk_busy_end: assert property ($rose(status_out.sr1[0]) |-> ##[1:BUSY_MAX] !status_out.sr1[0])
		else $error("busy too long");
	chk_wel_end: assert property ($fell(status_out.sr1[0]) |-> !status_out.sr1[1])
		else $error("latch kept after timed write");
	chk_lock_keep: assert property (!dev_reset_in |=> (status_out.sr2[5:3] &
		$past(status_out.sr2[5:3])) == $past(status_out.sr2[5:3])) else $error("lock bit fell");
	chk_ro_zero: assert property ({status_out.sr1[7], status_out.sr2[7], status_out.sr2[2],
		status_out.sr3[7], status_out.sr3[4:3]} == 6'h00) else $error("read-only bit set");
endmodule

bind sfs_core sfs_core_asserts #(.NV_WRITE_NS(NV_WRITE_NS)) sfs_core_asserts_i (
	.clk_in(clk_in), .reset_in(reset_in), .spi_cs_n_in(spi_cs_n_in),
	.spi_clk_in(spi_clk_in), .serial_in_pin_in(serial_in_pin_in),
	.dev_reset_in(dev_reset_in), .mem_op_done_in(mem_op_done_in),
	.addr_hi_valid_in(addr_hi_valid_in), .addr_hi_in(addr_hi_in),
	.serial_out_out(serial_out_out), .serial_out_oe_out(serial_out_oe_out),
	.status_out(status_out), .ext_addr_out(ext_addr_out),
	.ext_addr_active_out(ext_addr_active_out)
);

`default_nettype wire

// ===== testbench/sfs_host_model.sv
// serial host model that frames instructions for the status command block
`default_nettype none

module sfs_host_model (
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      si_out,
	input  wire logic so_in,
	input  wire logic so_oe_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// framing
	// ----------------------------------------
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b0;
	end

	// msb first, clock idles low; a bit not driven by the device reads unknown
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
		rx = 32'h0;
		cs_n_out = 1'b0;
		#62.5;
		for (int i = n - 1; i >= 0; i--) begin
			si_out = tx[i];
			#62.5;
			sclk_out = 1'b1;
			rx = {rx[30:0], so_oe_in ? so_in : 1'bx};
			#62.5;
			sclk_out = 1'b0;
		end
		// released data line shows the inverse of its last value
		si_out = ~si_out;
		#62.5;
		cs_n_out = 1'b1;
		#200;
	endtask
endmodule

`default_nettype wire

// ===== testbench/sfs_core_test.sv
// self-checking bench for the status command block
`default_nettype none

module sfs_core_test
	import sfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [31:0] tx;
		int          n;
		logic        rd;
		logic [15:0] rx;
		logic [23:0] st;
		logic [7:0]  ext;
	} sfs_row_t;

	logic        clk_in;
	logic        reset_in;
	logic        cs_n;
	logic        sclk;
	logic        si;
	logic        dev_reset;
	logic        op_done;
	logic        hi_valid;
	logic [7:0]  hi;
	logic        so;
	logic        so_oe;
	sfs_stat_t   status;
	logic [7:0]  ext;
	logic        ext_act;
	logic [31:0] rx;
	int          err_total;
	int          n_tests;

	sfs_row_t rows [27] = '{
		'{32'h06, 8, 1'h0, 16'h0, 24'h600202, 8'h00},
		'{32'h04, 8, 1'h0, 16'h0, 24'h600200, 8'h00},
		'{32'h03, 7, 1'h0, 16'h0, 24'h600200, 8'h00},
		'{32'h0C, 9, 1'h0, 16'h0, 24'h600200, 8'h00},
		'{32'h06, 8, 1'h0, 16'h0, 24'h600202, 8'h00},
		'{32'h01FF, 16, 1'h0, 16'h0, 24'h60027C, 8'h00},
		'{32'h0100, 16, 1'h0, 16'h0, 24'h60027C, 8'h00},
		'{32'h050000, 24, 1'h1, 16'h7C7C, 24'h60027C, 8'h00},
		'{32'h06, 8, 1'h0, 16'h0, 24'h60027E, 8'h00},
		'{32'h314A, 16, 1'h0, 16'h0, 24'h604A7C, 8'h00},
		'{32'h350000, 24, 1'h1, 16'h4A4A, 24'h604A7C, 8'h00},
		'{32'h06, 8, 1'h0, 16'h0, 24'h604A7E, 8'h00},
		'{32'h11F4, 16, 1'h0, 16'h0, 24'h644A7C, 8'h00},
		'{32'h150000, 24, 1'h1, 16'h6464, 24'h644A7C, 8'h00},
		'{32'h06, 8, 1'h0, 16'h0, 24'h644A7E, 8'h00},
		'{32'h010440, 24, 1'h0, 16'h0, 24'h644804, 8'h00},
		'{32'h06, 8, 1'h0, 16'h0, 24'h644806, 8'h00},
		'{32'h0108, 16, 1'h0, 16'h0, 24'h644808, 8'h00},
		'{32'hC512, 16, 1'h0, 16'h0, 24'h644808, 8'h00},
		'{32'h06, 8, 1'h0, 16'h0, 24'h64480A, 8'h00},
		'{32'hC512, 16, 1'h0, 16'h0, 24'h64480A, 8'h12},
		'{32'hC80000, 24, 1'h1, 16'h1212, 24'h64480A, 8'h12},
		'{32'h04, 8, 1'h0, 16'h0, 24'h644808, 8'h12},
		'{32'hB7, 8, 1'h0, 16'h0, 24'h654808, 8'h12},
		'{32'hE9, 8, 1'h0, 16'h0, 24'h644808, 8'h12},
		'{32'h50, 8, 1'h0, 16'h0, 24'h644808, 8'h12},
		'{32'h0110, 16, 1'h0, 16'h0, 24'h644810, 8'h12}
	};

	sfs_core #(.NV_WRITE_NS(3600)) sfs_core_i (
		.clk_in(clk_in), .reset_in(reset_in), .spi_cs_n_in(cs_n), .spi_clk_in(sclk),
		.serial_in_pin_in(si), .dev_reset_in(dev_reset), .mem_op_done_in(op_done),
		.addr_hi_valid_in(hi_valid), .addr_hi_in(hi), .serial_out_out(so),
		.serial_out_oe_out(so_oe), .status_out(status), .ext_addr_out(ext),
		.ext_addr_active_out(ext_act)
	);

	sfs_host_model sfs_host_model_i (
		.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so), .so_oe_in(so_oe)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic run(input logic [31:0] tx, input int n);
		int k;
		sfs_host_model_i.xfer(tx, n, rx);
		k = 0;
		while (status.sr1[0] !== 1'b0 && k < 1200) begin
			@(negedge clk_in);
			k++;
		end
		@(negedge clk_in);
	endtask

	task automatic chk_stat(input logic [23:0] exp);
		n_tests++;
		if (status !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, status, exp);
		end
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	initial begin
		#250us;
		err_total++;
		finish_test();
	end

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		err_total = 0;
		n_tests = 0;
		reset_in = 1'b1;
		dev_reset = 1'b0;
		op_done = 1'b0;
		hi_valid = 1'b0;
		hi = 8'h00;
		repeat (4) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clk_in);
		foreach (rows[i]) begin
			run(rows[i].tx, rows[i].n);
			chk_stat(rows[i].st);
			chk_val({8'h00, ext}, {8'h00, rows[i].ext});
			if (rows[i].rd) chk_val(rx[15:0], rows[i].rx);
		end
		run(32'hB7, 8);
		chk_val({15'h0000, ext_act}, 16'h0000);
		hi = 8'h5A;
		hi_valid = 1'b1;
		@(negedge clk_in);
		hi_valid = 1'b0;
		@(negedge clk_in);
		chk_val({8'h00, ext}, 16'h005A);
		run(32'hE9, 8);
		chk_val({15'h0000, ext_act}, 16'h0001);
		hi = 8'hA5;
		hi_valid = 1'b1;
		@(negedge clk_in);
		hi_valid = 1'b0;
		run(32'hC80000, 24);
		chk_val(rx[15:0], 16'h5A5A);
		dev_reset = 1'b1;
		@(negedge clk_in);
		dev_reset = 1'b0;
		@(negedge clk_in);
		chk_stat(24'h644808);
		chk_val({8'h00, ext}, 16'h0000);
		run(32'h06, 8);
		op_done = 1'b1;
		@(negedge clk_in);
		op_done = 1'b0;
		@(negedge clk_in);
		chk_stat(24'h644808);
		run(32'h06, 8);
		sfs_host_model_i.xfer(32'h0108, 16, rx);
		sfs_host_model_i.xfer(32'h0500, 16, rx);
		chk_val({8'h00, rx[7:0]}, 16'h000B);
		run(32'h05, 8);
		chk_stat(24'h644808);
		reset_in = 1'b1;
		@(negedge clk_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clk_in);
		chk_stat(24'h600200);
		chk_val({15'h0000, ext_act}, 16'h0001);
		finish_test();
	end
endmodule

`default_nettype wire
